// *** design/caf_filter.sv ***
// Purpose: Identifier tag and mask registers of the message objects
// Assumes: Core SFR strobes on clock_i; page pointer chooses the object
// Notes:   Contents undefined after reset; software loads before enabling
//
// Functional notes
// R1 - Mask bit 0 forces compare true; 1 compares received bit to tag.
// R2 - Masks filter reception only; transmit ignores them.
// R3 - Extended: tag bytes 1..3 hold id 28:21, 20:13, 12:5.
// R4 - Extended tag byte 4: id 4:0 at 7:3, remote 2, rb1 1, rb0 0.
// R5 - Standard tag byte 4: remote at 2, rb0 at 0, rest reserved.
// R6 - Standard: mask 10:3 in byte 1, 2:0 at byte 2 bits 7:5.
// R7 - Standard mask byte 4: remote mask 2, extension mask 0.
// R8 - Extended: mask bytes 1..3 hold mask 28:21, 20:13, 12:5.
// R9 - Software writes no ones to reserved bits; reads are indeterminate.
// R10 - No reset of tag or mask; software loads all before enabling.
// R11 - Extension setting picks 11-bit or 29-bit layout, same addresses.
// R12 - Standard: id 10:3 in tag byte 1, 2:0 at byte 2 bits 7:5.
// R13 - Extended mask byte 4: mask 4:0 at 7:3, remote 2, extension 0.
// R14 - Hit only when every enabled bit equals its tag value.
// R15 - Accesses go to the object chosen by the page pointer.
`timescale 1ns/1ps
`include "caf_regs.svh"
module caf_filter #(
  parameter int NUM_OBJ = `CAF_NUM_OBJ
) (
  // Clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       arst_n_i,
  // SFR access
  input  wire caf_pkg::caf_sfr_req_s      sfr_i,
  output logic      [7:0]                 rdata_o,
  output logic                            rvalid_o,
  output logic                            sel_o,
  // Per-object control
  input  wire logic [3:0]                 page_i,
  input  wire logic [NUM_OBJ-1:0]         ext_i,
  input  wire logic [NUM_OBJ-1:0]         rx_en_i,
  // Frame from protocol engine
  input  wire caf_pkg::caf_frame_s        frame_i,
  output logic [NUM_OBJ-1:0]              hit_o,
  output logic                            hit_valid_o
);
  localparam int WORDS = NUM_OBJ * `CAF_BYTES;
  localparam int AW    = $clog2(WORDS);
  // Bound on the wait from the first compare to the done pulse, one over the NUM_OBJ cycles of a pass
  localparam int SWEEP_MAX = NUM_OBJ + 1;

  initial
  begin
    // Row and address widths assume 72 to 128 filter bytes
    if (NUM_OBJ < 9 || NUM_OBJ > 16) $error("NUM_OBJ out of range");
  end

  typedef struct packed {
    logic               rvalid;
    logic [NUM_OBJ-1:0] hit;
    logic               hvalid;
    logic [3:0]         obj;
    logic [4:0]         age;
  } caf_state_s;

  caf_state_s st_q;
  caf_state_s st_d;

  // Byte index 0..7 within an object, or 4'hF when not mapped
  function automatic logic [3:0] byte_index(input logic [7:0] a);
    case (a)
      `CAF_ADDR_TAG1: byte_index = 4'h0;
      `CAF_ADDR_TAG2: byte_index = 4'h1;
      `CAF_ADDR_TAG3: byte_index = 4'h2;
      `CAF_ADDR_TAG4: byte_index = 4'h3;
      `CAF_ADDR_MSK1: byte_index = 4'h4;
      `CAF_ADDR_MSK2: byte_index = 4'h5;
      `CAF_ADDR_MSK3: byte_index = 4'h6;
      `CAF_ADDR_MSK4: byte_index = 4'h7;
      default:        byte_index = 4'hF;
    endcase
  endfunction : byte_index

  // True when an object number names an existing message object
  function automatic logic in_range(input logic [3:0] o);
    in_range = (32'(o) < NUM_OBJ);
  endfunction : in_range

  logic [3:0]     bidx;
  logic           page_ok;
  logic           we;
  logic [AW-1:0]  addr;
  logic [3:0]     scan_obj;
  logic [63:0]    row;
  logic [7:0]     mem_rdata;
  logic           row_hit;

  assign bidx    = byte_index(sfr_i.addr);
  assign page_ok = in_range(page_i);
  assign sel_o   = (bidx != 4'hF) && page_ok;
  // Selected object's row; layout fixed for both formats  // see R11 R15
  assign addr    = AW'({page_i, bidx[2:0]});
  assign we      = sfr_i.wr && sel_o; // see R3 R4 R5 R6 R7 R8 R12 R13
  assign rdata_o = mem_rdata;
  assign rvalid_o = st_q.rvalid;
  assign hit_o   = st_q.hit;
  assign hit_valid_o = st_q.hvalid;

  // Contents unreset: software must load every byte  // see R10
  caf_mem #(
    .WORDS (WORDS)
  ) u_mem (
    .clock_i (clock_i),
    .we_i    (we),
    .waddr_i (addr),
    .wdata_i (sfr_i.wdata),
    .raddr_i (addr),
    .rdata_o (mem_rdata),
    .row_i   (scan_obj),
    .row_o   (row)
  );

  caf_cmp u_cmp (
    .filt_i  (row),
    .ext_i   (ext_i[scan_obj]),
    .frame_i (frame_i),
    .hit_o   (row_hit)
  );

  assign scan_obj = st_q.obj;

  // One object per clock is compared; frame must hold during a sweep
  always_comb
  begin
    st_d        = st_q;
    st_d.rvalid = sfr_i.rd && sel_o;
    st_d.hvalid = 1'b0;
    if (!frame_i.valid)
    begin
      st_d.obj = 4'h0;
      st_d.hit = '0;
      st_d.age = 5'h00;
    end
    else if (in_range(st_q.obj))
    begin
      // Only receive-enabled objects filter  // see R2 R14
      st_d.hit[st_q.obj] = row_hit && rx_en_i[st_q.obj];
      st_d.obj = st_q.obj + 4'h1;
      st_d.hvalid = (32'(st_q.obj) == NUM_OBJ - 1);
    end
    // Frame age saturates; it times the sweep for the checks below
    if (frame_i.valid && st_q.age != 5'h1F)
      st_d.age = st_q.age + 5'h01;
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Register side checks

  // Accepted read answers on the next cycle
  a_read_valid: assert property ( // see R15
    @(posedge clock_i) disable iff (!arst_n_i)
      (sfr_i.rd && sel_o)
    |=>
      rvalid_o
  ) else $error("read not answered");

  // Refused read gives no answer
  a_read_refused: assert property ( // see R15
    @(posedge clock_i) disable iff (!arst_n_i)
      (sfr_i.rd && !sel_o)
    |=>
      !rvalid_o
  ) else $error("refused read was answered");

  // No answer without a read strobe
  a_no_idle_read: assert property ( // see R15
    @(posedge clock_i) disable iff (!arst_n_i)
      !sfr_i.rd
    |=>
      !rvalid_o
  ) else $error("answer without a read");

  // A page beyond the last object selects nothing
  a_page_bound: assert property ( // see R15
    @(posedge clock_i) disable iff (!arst_n_i)
      !in_range(page_i)
    |->
      !sel_o
  ) else $error("select on missing object");

  // All eight filter addresses map on a valid page
  a_tag_map: assert property ( // see R11
    @(posedge clock_i) disable iff (!arst_n_i)
      (in_range(page_i) && (sfr_i.addr inside {`CAF_ADDR_TAG1,
        `CAF_ADDR_TAG2, `CAF_ADDR_TAG3, `CAF_ADDR_TAG4, `CAF_ADDR_MSK1,
        `CAF_ADDR_MSK2, `CAF_ADDR_MSK3, `CAF_ADDR_MSK4}))
    |->
      sel_o
  ) else $error("filter address not selected");

  // A read right after a write to the same byte returns the new byte
  a_read_after_write: assert property ( // see R15
    @(posedge clock_i) disable iff (!arst_n_i)
      (we ##1 (sfr_i.rd && sel_o && addr == $past(addr)))
    |=>
      (rdata_o == $past(sfr_i.wdata, 2))
  ) else $error("read back differs from write");

  // Sweep checks

  // Sweep ends within one pass over the objects
  a_sweep_done: assert property ( // see R14
    @(posedge clock_i) disable iff (!arst_n_i)
      (frame_i.valid && st_q.obj == 4'h0 && !hit_valid_o)
    |->
      ##[1:SWEEP_MAX] (hit_valid_o || !frame_i.valid)
  ) else $error("sweep did not finish");

  // One object per clock while a frame stands
  a_sweep_step: assert property ( // see R14
    @(posedge clock_i) disable iff (!arst_n_i)
      (frame_i.valid && in_range(st_q.obj))
    |=>
      (st_q.obj == $past(st_q.obj) + 4'h1)
  ) else $error("sweep skipped an object");

  // Object counter never passes the end of the table
  a_sweep_bound: assert property ( // see R14
    @(posedge clock_i) disable iff (!arst_n_i)
      1'b1
    |->
      (32'(st_q.obj) <= NUM_OBJ)
  ) else $error("sweep ran past the last object");

  // Done comes exactly one pass after the frame arrived
  a_hvalid_last: assert property ( // see R14
    @(posedge clock_i) disable iff (!arst_n_i)
      hit_valid_o
    |->
      (st_q.age == 5'(NUM_OBJ))
  ) else $error("done pulse at wrong time");

  // Done is a single-cycle pulse
  a_hvalid_pulse: assert property ( // see R14
    @(posedge clock_i) disable iff (!arst_n_i)
      hit_valid_o
    |=>
      !hit_valid_o
  ) else $error("done pulse too long");

  // Finished hits hold while the frame stands
  a_hit_hold: assert property ( // see R14
    @(posedge clock_i) disable iff (!arst_n_i)
      (frame_i.valid && !in_range(st_q.obj))
    |=>
      $stable(hit_o)
  ) else $error("hits moved after the sweep");

  // Object not enabled for reception never hits
  a_no_rx_hit: assert property ( // see R2
    @(posedge clock_i) disable iff (!arst_n_i)
      (frame_i.valid && in_range(st_q.obj) && !rx_en_i[st_q.obj])
    |=>
      !hit_o[$past(st_q.obj)]
  ) else $error("hit on object not enabled for reception");

  // Final hit vector holds only receive-enabled objects
  a_hit_enabled: assert property ( // see R2
    @(posedge clock_i) disable iff (!arst_n_i)
      hit_valid_o
    |->
      ((hit_o & ~rx_en_i) == '0)
  ) else $error("final hit on disabled object");

  // Hits clear between frames
  a_idle_clear: assert property ( // see R14
    @(posedge clock_i) disable iff (!arst_n_i)
      !frame_i.valid
    |=>
      (hit_o == '0 && !hit_valid_o)
  ) else $error("hits not cleared between frames");

  // Sweep restarts from the first object for every frame
  a_idle_obj: assert property ( // see R14
    @(posedge clock_i) disable iff (!arst_n_i)
      !frame_i.valid
    |=>
      (st_q.obj == 4'h0 && st_q.age == 5'h00)
  ) else $error("sweep not rewound between frames");
endmodule : caf_filter

// *** pkg/caf_regs.svh ***
// Purpose: Addresses, field positions and counts for the acceptance filter
// Assumes: Byte-wide special-function-register port of the core
// Notes:   Tag and mask contents have no reset value
`ifndef CAF_REGS_SVH
`define CAF_REGS_SVH

`define CAF_ADDR_TAG1   8'hBC
`define CAF_ADDR_TAG2   8'hBD
`define CAF_ADDR_TAG3   8'hBE
`define CAF_ADDR_TAG4   8'hBF
`define CAF_ADDR_MSK1   8'hC4
`define CAF_ADDR_MSK2   8'hC5
`define CAF_ADDR_MSK3   8'hC6
`define CAF_ADDR_MSK4   8'hC7
`define CAF_RTR_BIT     2
`define CAF_RB1_BIT     1
`define CAF_RB0_BIT     0
`define CAF_IDE_BIT     0
`define CAF_NUM_OBJ     15
`define CAF_BYTES       8

`endif

// *** pkg/caf_pkg.sv ***
// Purpose: Types shared by the acceptance filter files
// Assumes: Nothing
// Notes:   Frame fields arrive from the protocol engine on the core clock
package caf_pkg;

  typedef struct packed {
    logic        valid;
    logic        ide;
    logic [28:0] id;
    logic        rtr;
    logic        rb1;
    logic        rb0;
  } caf_frame_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } caf_sfr_req_s;

endpackage : caf_pkg

// *** design/caf_mem.sv ***
// Purpose: Storage of filter bytes, one row per message object
// Assumes: One write port, one registered read port, one flat row read port
// Notes:   No reset on contents
`timescale 1ns/1ps
module caf_mem #(
  parameter int WORDS = 120
) (
  // Clock
  input  wire logic                       clock_i,
  // Write port
  input  wire logic                       we_i,
  input  wire logic [$clog2(WORDS)-1:0]   waddr_i,
  input  wire logic [7:0]                 wdata_i,
  // Registered read port
  input  wire logic [$clog2(WORDS)-1:0]   raddr_i,
  output logic      [7:0]                 rdata_o,
  // Row read for filtering
  input  wire logic [$clog2(WORDS)-4:0]   row_i,
  output logic      [63:0]                row_o
);
  logic [7:0] mem_q [WORDS];

  initial
  begin
    if (WORDS % 8 != 0) $error("WORDS must be a multiple of 8");
  end

  always_ff @(posedge clock_i)
  begin
    if (we_i)
      mem_q[waddr_i] <= wdata_i;
    rdata_o <= mem_q[raddr_i];
  end

  always_comb
  begin
    for (int b = 0; b < 8; b++)
      row_o[8*b +: 8] = mem_q[{row_i, 3'(b)}];
  end
endmodule : caf_mem

// *** design/caf_cmp.sv ***
// Purpose: Masked compare of a received frame against one object's filter
// Assumes: Tag and mask bytes laid out as in the register map
// Notes:   Pure combinational
`timescale 1ns/1ps
`include "caf_regs.svh"
module caf_cmp (
  // Filter bytes: tag 1..4 in [31:0] low first, mask 1..4 in [63:32]
  input  wire logic [63:0]          filt_i,
  input  wire logic                 ext_i,
  // Frame
  input  wire caf_pkg::caf_frame_s  frame_i,
  output logic                      hit_o
);
  logic [28:0] tag_id;
  logic [28:0] msk_id;
  logic [7:0]  t4;
  logic [7:0]  m4;
  logic [28:0] idv;

  always_comb
  begin
    t4 = filt_i[31:24];
    m4 = filt_i[63:56];
    idv = frame_i.id;
    tag_id = '0;
    msk_id = '0;
    if (ext_i)
    begin
      tag_id = {filt_i[7:0], filt_i[15:8], filt_i[23:16], t4[7:3]};
      msk_id = {filt_i[39:32], filt_i[47:40], filt_i[55:48], m4[7:3]};
    end
    else
    begin
      tag_id[10:0] = {filt_i[7:0], filt_i[15:13]};
      msk_id[10:0] = {filt_i[39:32], filt_i[47:45]};
      idv[28:11] = '0;
    end
    // Mask bit 0 forces true, 1 enables compare  // see R1 R14
    hit_o = frame_i.valid
          && (((idv ^ tag_id) & msk_id) == '0)
          && !((frame_i.rtr ^ t4[`CAF_RTR_BIT]) & m4[`CAF_RTR_BIT])
          && !((frame_i.ide ^ ext_i) & m4[`CAF_IDE_BIT]);
  end
endmodule : caf_cmp

// *** tb/caf_frame_src.sv ***
// Purpose: Protocol engine side, presents one received frame
// Assumes: Frame held until the sweep reports done
// Notes:   Released fields show the inverse of the last frame
`timescale 1ns/1ps
module caf_frame_src (
  // Clock and control
  input  wire logic                clock_i,
  input  wire logic                send_i,
  input  wire logic                done_i,
  // Frame
  input  wire caf_pkg::caf_frame_s want_i,
  output caf_pkg::caf_frame_s      frame_o
);
  caf_pkg::caf_frame_s fr_q = '0;
  caf_pkg::caf_frame_s fr_d;
  assign frame_o = fr_q;
  always_comb
  begin
    fr_d = fr_q;
    if (send_i)
      fr_d = want_i;
    else if (done_i)
      fr_d = {1'b0, ~fr_q[32:0]};
  end
  always_ff @(posedge clock_i)
  begin
    fr_q <= fr_d;
  end
endmodule : caf_frame_src

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench of the acceptance filter registers
// Assumes: Object 1 standard, object 2 extended
// Notes:   Unloaded objects hold undefined filters and are not judged
`timescale 1ns/1ps
`include "caf_regs.svh"
module tb_top;
  logic                  clock_i = 1'b0;
  logic                  arst_n_i = 1'b0;
  caf_pkg::caf_sfr_req_s sfr_i = '0;
  logic [3:0]            page_i = 4'h0;
  logic [14:0]           ext_i = 15'h0004;
  logic [14:0]           rx_en_i = 15'h0006;
  logic                  send = 1'b0;
  caf_pkg::caf_frame_s   want = '0;
  caf_pkg::caf_frame_s   frame;
  logic [7:0]            rdata_o;
  logic                  rvalid_o;
  logic                  sel_o;
  logic [14:0]           hit_o;
  logic                  hit_valid_o;
  int                    n_errors = 0;
  int                    checks_done = 0;
  int                    cyc = 0;
  localparam logic [63:0] STD_F = 64'hB460_0000_FFE0_0005;
  localparam logic [63:0] EXT_F = 64'hD5E6_F78C_FFFF_FFFD;

  caf_filter #(.NUM_OBJ(15)) caf_filter_i (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .sfr_i(sfr_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .sel_o(sel_o), .page_i(page_i), .ext_i(ext_i),
    .rx_en_i(rx_en_i), .frame_i(frame), .hit_o(hit_o),
    .hit_valid_o(hit_valid_o));
  caf_frame_src caf_frame_src_i (.clock_i(clock_i), .send_i(send),
    .done_i(hit_valid_o), .want_i(want), .frame_o(frame));

  initial forever #4 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      results();
    end
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask : chk1
  function automatic logic [7:0] adr(input int i);
    return 8'(i < 4 ? `CAF_ADDR_TAG1 + i : `CAF_ADDR_MSK1 + i - 4);
  endfunction : adr
  function automatic caf_pkg::caf_frame_s fr(input logic x,
    input logic [28:0] id, input logic r);
    return '{1'b1, x, id, r, 1'b0, 1'b0};
  endfunction : fr
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    sfr_i <= '{1'b1, 1'b0, a, d};
    @(posedge clock_i);
    sfr_i <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic ok);
    @(posedge clock_i);
    sfr_i <= '{1'b0, 1'b1, a, 8'h00};
    #1 chk1(sel_o, ok);
    @(posedge clock_i);
    sfr_i <= '0;
    #1 chk1(rvalid_o, ok);
    if (ok)
      chk8(rdata_o, e);
  endtask : rd
  task automatic ld(input logic [3:0] p, input logic [63:0] v);
    @(posedge clock_i);
    page_i <= p;
    for (int i = 0; i < 8; i++)
      wr(adr(i), v[63-8*i -: 8]);
  endtask : ld
  task automatic rb(input logic [3:0] p, input logic [63:0] v);
    @(posedge clock_i);
    page_i <= p;
    for (int i = 0; i < 8; i++)
      rd(adr(i), v[63-8*i -: 8], 1'b1);
  endtask : rb
  task automatic run(input caf_pkg::caf_frame_s f, input logic [1:0] e);
    int n;
    @(posedge clock_i);
    send <= 1'b1;
    want <= f;
    @(posedge clock_i);
    send <= 1'b0;
    n = 0;
    #1;
    while (hit_valid_o !== 1'b1 && n < 40)
    begin
      @(posedge clock_i);
      #1 n++;
    end
    chk1(hit_valid_o, 1'b1);
    chk8({6'h0, hit_o[2:1]}, {6'h0, e});
    repeat (2) @(posedge clock_i);
  endtask : run

  task automatic t_regs;
    ld(4'h1, STD_F);
    ld(4'h2, EXT_F);
    rb(4'h1, STD_F);
    rb(4'h2, EXT_F);
  endtask : t_regs
  task automatic t_std;
    run(fr(1'b0, 29'h5A3, 1'b0), 2'b01);
    run(fr(1'b0, 29'h5A2, 1'b0), 2'b00);
    run(fr(1'b0, 29'h5A3, 1'b1), 2'b00);
  endtask : t_std
  task automatic t_ext;
    run(fr(1'b1, 29'h1ABCDEF1, 1'b1), 2'b10);
    run(fr(1'b1, 29'h0ABCDEF1, 1'b1), 2'b00);
  endtask : t_ext
  task automatic t_mask;
    ld(4'h1, 64'hB460_0000_FFC0_0005);
    run(fr(1'b0, 29'h5A2, 1'b0), 2'b01);
  endtask : t_mask
  task automatic t_tx;
    @(posedge clock_i);
    rx_en_i <= 15'h0004;
    run(fr(1'b0, 29'h5A2, 1'b0), 2'b00);
    rx_en_i <= 15'h0006;
  endtask : t_tx
  task automatic t_b2b;
    @(posedge clock_i);
    page_i <= 4'h3;
    sfr_i <= '{1'b1, 1'b0, `CAF_ADDR_TAG1, 8'h5C};
    @(posedge clock_i);
    sfr_i <= '{1'b0, 1'b1, `CAF_ADDR_TAG1, 8'h00};
    @(posedge clock_i);
    sfr_i <= '0;
    #1 chk8(rdata_o, 8'h5C);
  endtask : t_b2b
  task automatic t_bad;
    rd(8'hC0, 8'h00, 1'b0);
    @(posedge clock_i);
    page_i <= 4'hF;
    rd(`CAF_ADDR_TAG1, 8'h00, 1'b0);
  endtask : t_bad

  task automatic results;
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_std();
    t_ext();
    t_mask();
    t_tx();
    t_b2b();
    t_bad();
    results();
  end
endmodule : tb_top
